/* File: src/xbar_consts.svh */
// Offsets, field positions, reset values and sizes of the pin crossbar
`ifndef XBAR_CONSTS_SVH
`define XBAR_CONSTS_SVH

`define ASSIGN_PINS 20
`define TOTAL_PINS 25
`define NUM_SIG 13
`define UART_TX_PIN 4
`define UART_RX_PIN 5

`define OFS_CTRL 8'h00
`define OFS_SKIP0 8'h04
`define OFS_SKIP1 8'h08
`define OFS_SKIP2 8'h0c
`define OFS_MODE0 8'h10
`define OFS_MODE1 8'h14
`define OFS_MODE2 8'h18
`define OFS_MODE3 8'h1c
`define OFS_PORT0 8'h20
`define OFS_PORT1 8'h24
`define OFS_PORT2 8'h28
`define OFS_PORT3 8'h2c
`define OFS_UNROUTED 8'h30

`define CTRL_W 10
`define CTRL_ROUTE_EN 0
`define CTRL_UART 1
`define CTRL_SPI 2
`define CTRL_SPI_NSS 3
`define CTRL_SMBUS 4
`define CTRL_CP0 5
`define CTRL_CP0A 6
`define CTRL_CP1 7
`define CTRL_CP1A 8
`define CTRL_SYSCLK 9

`define CTRL_RESET 10'h000
`define SKIP_RESET 8'h00
`define MODE_RESET 8'h00
`define LATCH_RESET 8'hff

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/xbar_pkg.sv */
// Types shared by the pin crossbar modules
package xbar_pkg;
	typedef enum logic [3:0] {
		SIG_NONE = 4'h0,
		SIG_UART_TX = 4'h1,
		SIG_UART_RX = 4'h2,
		SIG_SPI_SCK = 4'h3,
		SIG_SPI_MISO = 4'h4,
		SIG_SPI_MOSI = 4'h5,
		SIG_SPI_NSS = 4'h6,
		SIG_SMB_SDA = 4'h7,
		SIG_SMB_SCL = 4'h8,
		SIG_CP0 = 4'h9,
		SIG_CP0A = 4'ha,
		SIG_CP1 = 4'hb,
		SIG_CP1A = 4'hc,
		SIG_SYSCLK = 4'hd
	} sig_t;
endpackage

/* File: src/pin_decoder.sv */
// Priority decoder that places enabled peripheral signals onto routable pins
`include "xbar_consts.svh"
module pin_decoder #(
	parameter int ASSIGN_PINS = `ASSIGN_PINS
) (
	// Selections
	input wire logic [`NUM_SIG-1:0] sig_en,
	input wire logic [ASSIGN_PINS-1:0] skip,
	// Placement
	output xbar_pkg::sig_t pin_sel [ASSIGN_PINS],
	output logic [`NUM_SIG-1:0] unrouted
);
	import xbar_pkg::*;

	// Refuse a pin count that cannot hold the fixed serial pair
	if (ASSIGN_PINS < `UART_RX_PIN + 1 || ASSIGN_PINS > 32) begin : g_bad_pins
		$error("pin_decoder: ASSIGN_PINS out of range");
	end

	logic [ASSIGN_PINS-1:0] taken;
	logic found;

	always_comb begin
		// Skipped pins look as if already assigned
		taken = skip;
		unrouted = '0;
		found = 1'b0;
		for (int p = 0; p < ASSIGN_PINS; p++) begin
			pin_sel[p] = SIG_NONE;
		end
		// Fixed pins ignore the skip mask so bootloading always works
		if (sig_en[0]) begin
			pin_sel[`UART_TX_PIN] = SIG_UART_TX;
			pin_sel[`UART_RX_PIN] = SIG_UART_RX;
			taken[`UART_TX_PIN] = 1'b1;
			taken[`UART_RX_PIN] = 1'b1;
		end
		// Walk in priority order, each takes the lowest free pin
		for (int s = 2; s < `NUM_SIG; s++) begin
			found = 1'b0;
			if (sig_en[s]) begin
				for (int p = 0; p < ASSIGN_PINS; p++) begin
					if (!found && !taken[p]) begin
						pin_sel[p] = sig_t'(4'(s + 1));
						taken[p] = 1'b1;
						found = 1'b1;
					end
				end
				unrouted[s] = !found;
			end
		end
	end
endmodule

/* File: src/pin_cell.sv */
// One port pin driver: peripheral or latch, push-pull or open-drain
module pin_cell (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic active,
	input wire logic routed,
	input wire logic force_od,
	input wire logic push_pull,
	// Data sources
	input wire logic periph_val,
	input wire logic periph_drive,
	input wire logic latch_val,
	// Pin
	output logic pin_out,
	output logic pin_oe
);
	logic val;
	logic oe_nxt;

	always_comb begin
		val = routed ? periph_val : latch_val;
		if (!active) begin
			oe_nxt = 1'b0;
		end else if (routed && !periph_drive) begin
			oe_nxt = 1'b0;
		end else if (push_pull && !(routed && force_od)) begin
			oe_nxt = 1'b1;
		end else begin
			oe_nxt = !val;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= val;
			pin_oe <= oe_nxt;
		end
	end
endmodule

/* File: src/priority_pin_crossbar.sv */
// Pin crossbar top: AXI4-Lite registers, placement, pin drivers and checks
`include "xbar_consts.svh"
module priority_pin_crossbar (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral side, bit s-1 for signal s
	input wire logic [`NUM_SIG-1:0] periph_out,
	input wire logic [`NUM_SIG-1:0] periph_drive,
	output logic [`NUM_SIG-1:0] periph_in,
	// Port pins, index port*8+bit, port 3 pin 0 at the top
	input wire logic [`TOTAL_PINS-1:0] pin_in,
	output logic [`TOTAL_PINS-1:0] pin_out,
	output logic [`TOTAL_PINS-1:0] pin_oe
);
	import xbar_pkg::*;

	localparam int NP = `ASSIGN_PINS;
	localparam int TP = `TOTAL_PINS;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge8 = strb[0] ? d[7:0] : old;
	endfunction

	// Registers
	logic [`CTRL_W-1:0] ctrl_r;
	logic [7:0] skip_r [3];
	logic [7:0] mode_r [4];
	logic [7:0] latch_r [4];

	// Write channel
	logic aw_got_r, w_got_r, bvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r;
	logic aw_fire, w_fire, do_write, wr_mapped;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign do_write = (aw_got_r || aw_fire) && (w_got_r || w_fire) && !bvalid_r;
	assign wa = aw_got_r ? awaddr_r : s_axi_awaddr;
	assign wd = w_got_r ? wdata_r : s_axi_wdata;
	assign ws = w_got_r ? wstrb_r : s_axi_wstrb;
	assign wr_mapped = (wa[1:0] == 2'h0) && (wa <= `OFS_PORT3);
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			aw_got_r <= do_write ? 1'b0 : (aw_fire | aw_got_r);
			w_got_r <= do_write ? 1'b0 : (w_fire | w_got_r);
			if (aw_fire) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `CTRL_RESET;
			for (int i = 0; i < 3; i++) begin
				skip_r[i] <= `SKIP_RESET;
			end
			for (int i = 0; i < 4; i++) begin
				mode_r[i] <= `MODE_RESET;
				latch_r[i] <= `LATCH_RESET;
			end
		end else if (do_write && wr_mapped) begin
			case (wa)
				`OFS_CTRL: begin
					ctrl_r[7:0] <= merge8(ctrl_r[7:0], wd, ws);
					if (ws[1]) begin
						ctrl_r[`CTRL_W-1:8] <= wd[`CTRL_W-1:8];
					end
				end
				`OFS_SKIP0: skip_r[0] <= merge8(skip_r[0], wd, ws);
				`OFS_SKIP1: skip_r[1] <= merge8(skip_r[1], wd, ws);
				`OFS_SKIP2: skip_r[2] <= merge8(skip_r[2], wd, ws);
				`OFS_MODE0: mode_r[0] <= merge8(mode_r[0], wd, ws);
				`OFS_MODE1: mode_r[1] <= merge8(mode_r[1], wd, ws);
				`OFS_MODE2: mode_r[2] <= merge8(mode_r[2], wd, ws);
				`OFS_MODE3: mode_r[3] <= merge8(mode_r[3], wd, ws);
				`OFS_PORT0: latch_r[0] <= merge8(latch_r[0], wd, ws);
				`OFS_PORT1: latch_r[1] <= merge8(latch_r[1], wd, ws);
				`OFS_PORT2: latch_r[2] <= merge8(latch_r[2], wd, ws);
				`OFS_PORT3: latch_r[3] <= merge8(latch_r[3], wd, ws);
				default: ;
			endcase
		end
	end

	// Placement
	logic route_en;
	logic [`NUM_SIG-1:0] sig_en;
	logic [NP-1:0] skip_all;
	logic [TP-1:0] mode_all, latch_all;
	sig_t pin_sel [NP];
	logic [`NUM_SIG-1:0] unrouted;

	assign route_en = ctrl_r[`CTRL_ROUTE_EN];
	// Paired interfaces raise both of their enables together
	assign sig_en[0] = ctrl_r[`CTRL_UART];
	assign sig_en[1] = ctrl_r[`CTRL_UART];
	assign sig_en[2] = ctrl_r[`CTRL_SPI];
	assign sig_en[3] = ctrl_r[`CTRL_SPI];
	assign sig_en[4] = ctrl_r[`CTRL_SPI];
	assign sig_en[5] = ctrl_r[`CTRL_SPI] && ctrl_r[`CTRL_SPI_NSS];
	assign sig_en[6] = ctrl_r[`CTRL_SMBUS];
	assign sig_en[7] = ctrl_r[`CTRL_SMBUS];
	assign sig_en[8] = ctrl_r[`CTRL_CP0];
	assign sig_en[9] = ctrl_r[`CTRL_CP0A];
	assign sig_en[10] = ctrl_r[`CTRL_CP1];
	assign sig_en[11] = ctrl_r[`CTRL_CP1A];
	assign sig_en[12] = ctrl_r[`CTRL_SYSCLK];
	assign skip_all = {skip_r[2][3:0], skip_r[1], skip_r[0]};
	assign mode_all = {mode_r[3][0], mode_r[2], mode_r[1], mode_r[0]};
	assign latch_all = {latch_r[3][0], latch_r[2], latch_r[1], latch_r[0]};

	pin_decoder #(
		.ASSIGN_PINS(NP)
	) u_decoder (
		.sig_en(sig_en),
		.skip(skip_all),
		.pin_sel(pin_sel),
		.unrouted(unrouted)
	);

	// Pins past the routable range never see the decoder
	genvar g;
	generate
		for (g = 0; g < TP; g++) begin : g_pin
			sig_t sel;
			logic routed;
			assign sel = (g < NP) ? pin_sel[(g < NP) ? g : 0] : SIG_NONE;
			assign routed = (sel != SIG_NONE);
			pin_cell u_cell (
				.aclk(aclk),
				.aresetn(aresetn),
				.active((g >= NP) || route_en),
				.routed(routed),
				.force_od(sel == SIG_SMB_SDA || sel == SIG_SMB_SCL),
				.push_pull(mode_all[g]),
				.periph_val(routed ? periph_out[4'(sel) - 4'h1] : 1'b0),
				.periph_drive(routed ? periph_drive[4'(sel) - 4'h1] : 1'b0),
				.latch_val(latch_all[g]),
				.pin_out(pin_out[g]),
				.pin_oe(pin_oe[g])
			);
		end
	endgenerate

	// Unplaced or disabled signals read idle high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_in <= '1;
		end else begin
			for (int s = 0; s < `NUM_SIG; s++) begin
				periph_in[s] <= 1'b1;
				for (int p = 0; p < NP; p++) begin
					if (route_en && pin_sel[p] == sig_t'(4'(s + 1))) begin
						periph_in[s] <= pin_in[p];
					end
				end
			end
		end
	end

	// Read channel
	logic rvalid_r;
	logic [31:0] rdata_r, rd_nxt;
	logic [1:0] rresp_r;
	logic rd_ok;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_comb begin
		rd_nxt = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFS_CTRL: rd_nxt[`CTRL_W-1:0] = ctrl_r;
			`OFS_SKIP0: rd_nxt[7:0] = skip_r[0];
			`OFS_SKIP1: rd_nxt[7:0] = skip_r[1];
			`OFS_SKIP2: rd_nxt[7:0] = skip_r[2];
			`OFS_MODE0: rd_nxt[7:0] = mode_r[0];
			`OFS_MODE1: rd_nxt[7:0] = mode_r[1];
			`OFS_MODE2: rd_nxt[7:0] = mode_r[2];
			`OFS_MODE3: rd_nxt[7:0] = mode_r[3];
			// Ports read the pins, not the latch
			`OFS_PORT0: rd_nxt[7:0] = pin_in[7:0];
			`OFS_PORT1: rd_nxt[7:0] = pin_in[15:8];
			`OFS_PORT2: rd_nxt[7:0] = pin_in[23:16];
			`OFS_PORT3: rd_nxt[0] = pin_in[24];
			`OFS_UNROUTED: rd_nxt[`NUM_SIG-1:0] = unrouted;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_nxt;
			rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Helpers for the checks
	logic order_ok, skip_hit, free_left;
	logic [`NUM_SIG-1:0] placed;
	always_comb begin
		sig_t last;
		last = SIG_NONE;
		order_ok = 1'b1;
		skip_hit = 1'b0;
		free_left = 1'b0;
		placed = '0;
		for (int p = 0; p < NP; p++) begin
			if (pin_sel[p] != SIG_NONE && pin_sel[p] != SIG_UART_TX
				&& pin_sel[p] != SIG_UART_RX) begin
				if (pin_sel[p] <= last) begin
					order_ok = 1'b0;
				end
				last = pin_sel[p];
				skip_hit = skip_hit | skip_all[p];
			end
			if (pin_sel[p] == SIG_NONE && !skip_all[p]) begin
				free_left = 1'b1;
			end
			if (pin_sel[p] != SIG_NONE) begin
				placed[4'(pin_sel[p]) - 4'h1] = 1'b1;
			end
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	uart_fixed_a: assert property (sig_en[0] |-> pin_sel[4] == SIG_UART_TX
		&& pin_sel[5] == SIG_UART_RX)
		else $error("serial port not on fixed pins");
	prio_order_a: assert property (order_ok)
		else $error("placement out of priority order");
	lowest_free_a: assert property (sig_en[2] && !skip_all[0]
		|-> pin_sel[0] == SIG_SPI_SCK)
		else $error("first placed signal not on lowest pin");
	skip_honour_a: assert property (!skip_hit)
		else $error("signal placed on skipped pin");
	unrouted_full_a: assert property (|unrouted |-> !free_left)
		else $error("signal unrouted while a pin is free");
	pair_claim_a: assert property (sig_en[6] |-> (placed[6] || unrouted[6])
		&& (placed[7] || unrouted[7]))
		else $error("bus pin neither placed nor flagged");
	off_quiet_a: assert property (!route_en |=> pin_oe[NP-1:0] == '0)
		else $error("routable pin driven while routing off");
	gpio_always_a: assert property (mode_all[24] |=> pin_oe[24])
		else $error("top pin not driven in push-pull");
	push_pull_a: assert property (route_en && pin_sel[0] == SIG_NONE && mode_all[0]
		|=> pin_oe[0] && pin_out[0] == $past(latch_all[0]))
		else $error("push-pull pin not driving latch");
	pin_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == `OFS_PORT0 |=> s_axi_rdata[7:0] == $past(pin_in[7:0]))
		else $error("port read differs from pin level");

	uart_spi_c: cover property (sig_en[0] && sig_en[2] && route_en);
	crystal_skip_c: cover property (skip_r[0] == 8'h0c && sig_en[2]);
	unrouted_c: cover property (|unrouted);
	enable_c: cover property (!route_en ##1 route_en);
endmodule

/* File: bench/pin_world.sv */
// Board model of the port pins seen from outside the block
module pin_world (
	// From the block
	input wire logic [24:0] pin_out,
	input wire logic [24:0] pin_oe,
	// Board levels
	input wire logic [24:0] ext_level,
	output logic [24:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin shows the board level, never the last value driven
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: bench/priority_pin_crossbar_bench.sv */
// Self-checking bench for the pin crossbar
`include "xbar_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch at %0t got %h exp %h", $time, a, b); end end
module priority_pin_crossbar_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic [12:0] periph_out = 13'h0;
	logic [12:0] periph_drive = 13'h0;
	logic [12:0] periph_in;
	logic [24:0] pin_in, pin_out, pin_oe;
	// Pin levels form a mixed pattern so a misplaced signal can read wrong, though some neighbours (pins 1 and 2) match
	logic [24:0] ext_level = 25'h1a5c396;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;

	priority_pin_crossbar uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_out, .periph_drive, .periph_in,
		.pin_in, .pin_out, .pin_oe);
	pin_world board (.pin_out, .pin_oe, .ext_level, .pin_in);

	always #5 aclk = ~aclk;

	task automatic results;
		$display("tests %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdreg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Register change shows at the pins one stage later, then one more to periph_in
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask

	// p[s] is the pin of signal code s+1: -1 not enabled, -2 enabled but left out
	task automatic check_map(input int p [13]);
		logic [12:0] ein, eunr;
		settle();
		for (int s = 0; s < 13; s++) begin
			ein[s] = (p[s] >= 0) ? ext_level[p[s]] : 1'b1;
			eunr[s] = (p[s] == -2);
		end
		`CHK(periph_in, ein)
		`CHK(pin_oe, 25'h0)
		rdreg(`OFS_UNROUTED);
		`CHK(rd[12:0], eunr)
	endtask

	task automatic t_reset;
		`CHK(pin_oe, 25'h0)
		`CHK(periph_in, 13'h1fff)
		wr(8'h40, 32'h1);
		`CHK(resp, `RESP_SLVERR)
		rdreg(8'h40);
		`CHK(resp, `RESP_SLVERR)
		`CHK(rd, 32'h0)
		// Serial selected and driving, but routing still off
		wr(`OFS_MODE0, 32'hff);
		wr(`OFS_CTRL, 32'h002);
		periph_drive <= 13'h1;
		periph_out <= 13'h1;
		settle();
		`CHK(pin_oe, 25'h0)
		`CHK(periph_in[1], 1'b1)
		periph_drive <= 13'h0;
		// Back to open-drain so idle latches do not drive later maps
		wr(`OFS_MODE0, 32'h00);
		$display("test reset done");
	endtask

	task automatic t_prio;
		// Serial, SPI with select, two-wire bus, CP0, clock out
		wr(`OFS_CTRL, 32'h23f);
		check_map('{4, 5, 0, 1, 2, 3, 6, 7, 8, -1, -1, -1, 9});
		$display("test priority done");
	endtask

	task automatic t_skip;
		wr(`OFS_SKIP0, 32'h0c);
		wr(`OFS_CTRL, 32'h3f1);
		check_map('{-1, -1, -1, -1, -1, -1, 0, 1, 4, 5, 6, 7, 8});
		$display("test skip done");
	endtask

	task automatic t_full;
		wr(`OFS_SKIP0, 32'hff);
		wr(`OFS_SKIP1, 32'hff);
		wr(`OFS_SKIP2, 32'h0e);
		wr(`OFS_CTRL, 32'h015);
		check_map('{-1, -1, 16, -2, -2, -1, -2, -2, -1, -1, -1, -1, -1});
		wr(`OFS_SKIP0, 32'h00);
		wr(`OFS_SKIP1, 32'h00);
		wr(`OFS_SKIP2, 32'h00);
		$display("test full done");
	endtask

	task automatic t_mode;
		logic m, v, eoe, lvl;
		wr(`OFS_CTRL, 32'h003);
		periph_drive <= 13'h1;
		for (int i = 0; i < 4; i++) begin
			m = (i == 0 || i == 3);
			v = (i < 2);
			eoe = m | ~v;
			lvl = eoe ? v : ext_level[4];
			// Pin 0 stays free in push-pull, so it drives its latch high
			wr(`OFS_MODE0, {27'h0, m, 4'h1});
			periph_out <= {12'h0, v};
			settle();
			`CHK(pin_oe[4], eoe)
			if (eoe) `CHK(pin_out[4], v)
			`CHK(pin_oe[0], 1'b1)
			`CHK(pin_out[0], 1'b1)
			rdreg(`OFS_PORT0);
			`CHK(rd[7:0], {ext_level[7:5], lvl, ext_level[3:1], 1'b1})
		end
		periph_drive <= 13'h0;
		$display("test mode done");
	endtask

	task automatic t_gpio;
		wr(`OFS_CTRL, 32'h000);
		wr(`OFS_MODE2, 32'hf0);
		wr(`OFS_MODE3, 32'h01);
		wr(`OFS_PORT2, 32'h0f);
		wr(`OFS_PORT3, 32'h00);
		settle();
		`CHK(pin_oe[24:20], 5'h1f)
		`CHK(pin_out[24:20], 5'h00)
		`CHK(pin_oe[19:0], 20'h0)
		rdreg(`OFS_PORT2);
		`CHK(rd[7:0], {4'h0, ext_level[19:16]})
		$display("test gpio done");
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_prio();
		t_skip();
		t_full();
		t_mode();
		t_gpio();
		results();
	end
endmodule
